/* File: hw/rct_pkg.sv */
// rct_pkg: register map, field positions, reset values and timing constants
// of the countdown timer and interrupt gating block.
// assumes a 32.768 kHz oscillator tick delivered as a one-cycle enable on sys_clk.
package rct_pkg;

    localparam longint unsigned OSC_HZ     = 32768;
    localparam longint unsigned NS_PER_SEC = 1_000_000_000;

    // register addresses
    localparam logic [4:0] ADDR_CTRL1     = 5'h00;
    localparam logic [4:0] ADDR_CTRL2     = 5'h01;
    localparam logic [4:0] ADDR_OFFSET    = 5'h02;
    localparam logic [4:0] ADDR_ALM_FIRST = 5'h0B;
    localparam logic [4:0] ADDR_ALM_LAST  = 5'h0F;
    localparam logic [4:0] ADDR_TMR_VAL   = 5'h10;
    localparam logic [4:0] ADDR_TMR_MODE  = 5'h11;
    localparam int         NUM_ALM        = 5;

    // field positions
    localparam int C2_AIE   = 7;
    localparam int C2_AF    = 6;
    localparam int C2_MI    = 5;
    localparam int C2_HMI   = 4;
    localparam int C2_TF    = 3;
    localparam int OFS_FAST = 7;
    localparam int ALM_DIS  = 7;
    localparam int TM_TD_HI = 4;
    localparam int TM_TD_LO = 3;
    localparam int TM_TE    = 2;
    localparam int TM_TIE   = 1;
    localparam int TM_PULSE = 0;

    // reset values and commands
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [7:0] ONE8         = 8'h01;
    localparam logic [7:0] ALM_RST      = 8'h80;
    localparam logic [7:0] TMR_MODE_RST = 8'h18;
    localparam logic [7:0] SOFT_RST_CMD = 8'h58;

    typedef enum logic [1:0] {SRC_4K, SRC_64, SRC_1S, SRC_60S} rct_src_t;

    // oscillator divider taps
    localparam logic [14:0] DIV_4K_MASK = 15'h0007;
    localparam logic [14:0] DIV_64_MASK = 15'h01FF;
    localparam logic [14:0] DIV_1S_MASK = 15'h7FFF;
    localparam logic [5:0]  SEC_LAST    = 6'h3B;

    typedef logic [9:0] rct_pw_t;

    // pulse widths, counted in oscillator ticks, least time rounded up
    localparam longint unsigned PW_122_NS   = 122_000;
    localparam longint unsigned PW_244_NS   = 244_000;
    localparam longint unsigned PW_7812_NS  = 7_812_000;
    localparam longint unsigned PW_15625_NS = 15_625_000;

    function automatic rct_pw_t osc_cycles(input longint unsigned ns);
        longint unsigned c;
        c = (ns * OSC_HZ + NS_PER_SEC - 1) / NS_PER_SEC;
        if (c == 0)
        begin
            c = 1;
        end
        return rct_pw_t'(c);
    endfunction : osc_cycles

    localparam rct_pw_t PW_122_OSC   = osc_cycles(PW_122_NS);
    localparam rct_pw_t PW_244_OSC   = osc_cycles(PW_244_NS);
    localparam rct_pw_t PW_7812_OSC  = osc_cycles(PW_7812_NS);
    localparam rct_pw_t PW_15625_OSC = osc_cycles(PW_15625_NS);
    localparam rct_pw_t PW_ZERO      = 10'h000;

endpackage : rct_pkg

/* File: hw/rct_tick_if.sv */
// rct_tick_if: source ticks and pulse-generator handshake inside the block.
// assumes the tick and pg_start signals are one-cycle enables on sys_clk; pg_width is a value and pg_pulse a level.
`timescale 1ns/1ps
interface rct_tick_if;
    import rct_pkg::*;
    logic    osc_tick;
    logic    tick_4k;
    logic    tick_64;
    logic    tick_1s;
    logic    tick_60s;
    logic    pg_start;
    rct_pw_t pg_width;
    logic    pg_pulse;

    modport gen   (output tick_4k, tick_64, tick_1s, tick_60s);
    modport pulse (input osc_tick, pg_start, pg_width, output pg_pulse);
    modport core  (input osc_tick, tick_4k, tick_64, tick_1s, tick_60s, pg_pulse,
                   output pg_start, pg_width);
endinterface : rct_tick_if

/* File: hw/rct_tick_gen.sv */
// rct_tick_gen: divides the oscillator tick into the four countdown sources.
// assumes osc_tick is a one-cycle enable; the divider runs free of the timer
// enable, which is what makes the first period shorter than nominal.
`timescale 1ns/1ps
module rct_tick_gen
    import rct_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  osc_tick,
    input  wire logic  soft_rst,
    rct_tick_if.gen    tif
);
    logic [14:0] div_q;
    logic [5:0]  sec_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            div_q <= '0;
        else if (ce && osc_tick)
            div_q <= div_q + 15'h0001;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            sec_q <= '0;
        else if (ce && soft_rst)
            sec_q <= '0;
        else if (ce && tif.tick_1s)
            sec_q <= (sec_q == SEC_LAST) ? 6'h00 : sec_q + 6'h01;
    end

    assign tif.tick_4k  = ce && osc_tick && ((div_q & DIV_4K_MASK) == DIV_4K_MASK);
    assign tif.tick_64  = ce && osc_tick && ((div_q & DIV_64_MASK) == DIV_64_MASK);
    assign tif.tick_1s  = ce && osc_tick && (div_q == DIV_1S_MASK);
    assign tif.tick_60s = tif.tick_1s && (sec_q == SEC_LAST);

endmodule : rct_tick_gen

/* File: hw/rct_pulse_gen.sv */
// rct_pulse_gen: stretches a countdown end into an interrupt pulse.
// assumes widths are given in oscillator ticks, so they do not move with offset mode.
`timescale 1ns/1ps
module rct_pulse_gen
    import rct_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  soft_rst,
    rct_tick_if.pulse  tif
);
    rct_pw_t cnt_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= PW_ZERO;
        else if (ce)
        begin
            if (soft_rst)
                cnt_q <= PW_ZERO;
            else if (tif.pg_start)
                cnt_q <= tif.pg_width;
            else if (tif.osc_tick && cnt_q != PW_ZERO)
                cnt_q <= cnt_q - 10'h001;
        end
    end

    assign tif.pg_pulse = (cnt_q != PW_ZERO);

    a_pulse_width_load: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && tif.pg_start && !soft_rst) |=> (cnt_q == $past(tif.pg_width)))
        else $error("pulse width not loaded");

endmodule : rct_pulse_gen

/* File: hw/rct_timer_top.sv */
// rct_timer_top: countdown timer, timer flag, alarm flag and interrupt pin
// gating of a real-time clock, with its registers on a simple byte port.
// assumes the serial front end turns host accesses into reg_wr/reg_rd strokes,
// and the calendar supplies the current time plus a pulse when it advances.
//
// Notes on behaviour
// - with alarm interrupt enabled the interrupt pin follows the alarm flag
// - alarm flag sticks until cleared; sets again only on a fresh match
// - alarm fields with their disable bit at one are not compared
// - timer flag sets on countdown end and on minute or half-minute events
// - timer flag is readable and only a software write of zero or the soft reset command clears it
// - level mode: pin follows timer flag, no new interrupt while flag stays
// - pulse mode: countdown repeats, a pulse every period regardless of flag
// - pulse widths depend on source clock and load value, start with flag
// - source select 00/01/10/11 gives 4.096 kHz, 64 Hz, 1 Hz, 1/60 Hz
// - eight-bit counter loaded at 10h; zero halts the timer
// - decrementing from one sets flag, reloads, starts the next period
// - a value written mid-period takes effect at once
// - first period after enable may be short; later periods exact
// - timer interrupt enable gates the pin; mode bit picks pulse or level
// - reading 10h returns the live counter, not the reload value
// - offset pulses may stretch or shrink 1 Hz, 1/60 Hz, fast-mode 64 Hz
// - reset: timer off, source 1/60 Hz, interrupt enables clear
// - alarm flag sets when all enabled comparisons first match the time
`timescale 1ns/1ps
module rct_timer_top
    import rct_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             osc_tick,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [4:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic             time_adv,
    input  wire logic [6:0]       cur_sec,
    input  wire logic [6:0]       cur_min,
    input  wire logic [6:0]       cur_hour,
    input  wire logic [6:0]       cur_date,
    input  wire logic [6:0]       cur_wday,
    input  wire logic             minute_event,
    input  wire logic             comp_extra,
    input  wire logic             comp_drop,
    output logic                  int_n
);
    rct_tick_if tif ();

    logic             wr;
    logic             soft_rst;
    logic             wr_ctrl2;
    logic             wr_val;
    logic             alarm_irq_enable_q;
    logic             alarm_flag_q;
    logic             minute_irq_enable_q;
    logic             half_minute_irq_enable_q;
    logic             countdown_flag_q;
    logic [7:0]       offset_q;
    logic [7:0]       alm_q [NUM_ALM];
    logic [CNT_W-1:0] countdown_load_value_q;
    logic [CNT_W-1:0] cnt_q;
    rct_src_t         countdown_source_select_q;
    logic             countdown_run_enable_q;
    logic             countdown_irq_enable_q;
    logic             countdown_irq_pulse_select_q;
    logic             match_prev_q;
    logic             src_tick;
    logic             comp_ok;
    logic             cnt_tick;
    logic             run;
    logic             end_evt;
    logic             match;
    logic             any_enabled;
    logic             tf_set;
    logic             af_set;
    logic             int_n_d;
    logic [7:0]       rdata_d;

    // an alarm field counts as hit when disabled or equal to the time
    function automatic logic field_hit(input logic [7:0] alm, input logic [6:0] cur);
        return alm[ALM_DIS] || (alm[6:0] == cur);
    endfunction : field_hit

    rct_tick_gen u_tick_gen (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .ce       (ce),
        .osc_tick (osc_tick),
        .soft_rst (soft_rst),
        .tif      (tif.gen)
    );

    rct_pulse_gen u_pulse_gen (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .ce       (ce),
        .soft_rst (soft_rst),
        .tif      (tif.pulse)
    );

    assign tif.osc_tick = ce && osc_tick;
    assign wr           = ce && reg_wr;
    assign soft_rst     = wr && reg_addr == ADDR_CTRL1 && reg_wdata == SOFT_RST_CMD;
    assign wr_ctrl2     = wr && reg_addr == ADDR_CTRL2;
    assign wr_val       = wr && reg_addr == ADDR_TMR_VAL;

    // source clock choice and offset compensation
    always_comb
    begin
        unique case (countdown_source_select_q)
            SRC_4K:  src_tick = tif.tick_4k;
            SRC_64:  src_tick = tif.tick_64;
            SRC_1S:  src_tick = tif.tick_1s;
            SRC_60S: src_tick = tif.tick_60s;
        endcase
    end

    assign comp_ok  = (offset_q[6:0] != 7'h00)
                   && (countdown_source_select_q == SRC_1S
                   ||  countdown_source_select_q == SRC_60S
                   || (countdown_source_select_q == SRC_64 && offset_q[OFS_FAST]));
    assign cnt_tick = comp_ok ? ((src_tick && !comp_drop) || comp_extra) : src_tick;
    assign run      = countdown_run_enable_q && countdown_load_value_q != '0;
    assign end_evt  = run && cnt_tick && cnt_q == CNT_W'(ONE8);

    // pulse width by source and load value
    always_comb
    begin
        unique case (countdown_source_select_q)
            SRC_4K:  tif.pg_width = (countdown_load_value_q == CNT_W'(ONE8))
                                    ? PW_122_OSC : PW_244_OSC;
            SRC_64:  tif.pg_width = (countdown_load_value_q == CNT_W'(ONE8))
                                    ? PW_7812_OSC : PW_15625_OSC;
            default: tif.pg_width = PW_15625_OSC;
        endcase
    end
    assign tif.pg_start = end_evt;

    // control_status_reg enables
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            alarm_irq_enable_q       <= 1'b0;
            minute_irq_enable_q      <= 1'b0;
            half_minute_irq_enable_q <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                alarm_irq_enable_q       <= 1'b0;
                minute_irq_enable_q      <= 1'b0;
                half_minute_irq_enable_q <= 1'b0;
            end
            else if (wr_ctrl2)
            begin
                alarm_irq_enable_q       <= reg_wdata[C2_AIE];
                minute_irq_enable_q      <= reg_wdata[C2_MI];
                half_minute_irq_enable_q <= reg_wdata[C2_HMI];
            end
        end
    end

    // timer flag: writing zero clears, writing one keeps; a set wins
    assign tf_set = end_evt
                 || (minute_event && (minute_irq_enable_q || half_minute_irq_enable_q));
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            countdown_flag_q <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                countdown_flag_q <= 1'b0;
            else if (tf_set)
                countdown_flag_q <= 1'b1;
            else if (wr_ctrl2 && !reg_wdata[C2_TF])
                countdown_flag_q <= 1'b0;
        end
    end

    // alarm compare; only a change into match sets the flag
    always_comb
    begin
        match       = field_hit(alm_q[0], cur_sec) && field_hit(alm_q[1], cur_min)
                   && field_hit(alm_q[2], cur_hour) && field_hit(alm_q[3], cur_date)
                   && field_hit(alm_q[4], cur_wday);
        any_enabled = 1'b0;
        for (int i = 0; i < NUM_ALM; i++)
        begin
            any_enabled = any_enabled || !alm_q[i][ALM_DIS];
        end
    end
    assign af_set = time_adv && match && any_enabled && !match_prev_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            match_prev_q <= 1'b0;
        else if (ce && time_adv)
            match_prev_q <= match && any_enabled;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            alarm_flag_q <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                alarm_flag_q <= 1'b0;
            else if (af_set)
                alarm_flag_q <= 1'b1;
            else if (wr_ctrl2 && !reg_wdata[C2_AF])
                alarm_flag_q <= 1'b0;
        end
    end

    // offset and alarm registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            offset_q <= ZERO8;
            for (int i = 0; i < NUM_ALM; i++)
                alm_q[i] <= ALM_RST;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                offset_q <= ZERO8;
                for (int i = 0; i < NUM_ALM; i++)
                    alm_q[i] <= ALM_RST;
            end
            else if (wr && reg_addr == ADDR_OFFSET)
                offset_q <= reg_wdata;
            else if (wr && reg_addr >= ADDR_ALM_FIRST && reg_addr <= ADDR_ALM_LAST)
                alm_q[3'(reg_addr - ADDR_ALM_FIRST)] <= reg_wdata;
        end
    end

    // timer mode register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            countdown_source_select_q    <= rct_src_t'(TMR_MODE_RST[TM_TD_HI:TM_TD_LO]);
            countdown_run_enable_q       <= TMR_MODE_RST[TM_TE];
            countdown_irq_enable_q       <= TMR_MODE_RST[TM_TIE];
            countdown_irq_pulse_select_q <= TMR_MODE_RST[TM_PULSE];
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                countdown_source_select_q    <= rct_src_t'(TMR_MODE_RST[TM_TD_HI:TM_TD_LO]);
                countdown_run_enable_q       <= TMR_MODE_RST[TM_TE];
                countdown_irq_enable_q       <= TMR_MODE_RST[TM_TIE];
                countdown_irq_pulse_select_q <= TMR_MODE_RST[TM_PULSE];
            end
            else if (wr && reg_addr == ADDR_TMR_MODE)
            begin
                countdown_source_select_q    <= rct_src_t'(reg_wdata[TM_TD_HI:TM_TD_LO]);
                countdown_run_enable_q       <= reg_wdata[TM_TE];
                countdown_irq_enable_q       <= reg_wdata[TM_TIE];
                countdown_irq_pulse_select_q <= reg_wdata[TM_PULSE];
            end
        end
    end

    // reload value and live counter; the divider is not restarted on enable,
    // so the first period lands between n-1 and n source ticks
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            countdown_load_value_q <= '0;
        else if (ce)
        begin
            if (soft_rst)
                countdown_load_value_q <= '0;
            else if (wr_val)
                countdown_load_value_q <= reg_wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else if (ce)
        begin
            if (soft_rst)
                cnt_q <= '0;
            else if (wr_val)
                cnt_q <= reg_wdata[CNT_W-1:0];
            else if (run && cnt_tick)
                cnt_q <= end_evt ? countdown_load_value_q : cnt_q - CNT_W'(ONE8);
        end
    end

    // interrupt pin, active low, from a flop
    assign int_n_d = !((alarm_irq_enable_q && alarm_flag_q)
                   || (countdown_irq_enable_q
                       && (countdown_irq_pulse_select_q ? tif.pg_pulse
                                                        : countdown_flag_q)));
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            int_n <= 1'b1;
        else if (ce)
            int_n <= int_n_d;
    end

    // register read, answered one edge after reg_rd
    always_comb
    begin
        rdata_d = ZERO8;
        if (reg_addr == ADDR_CTRL2)
        begin
            rdata_d[C2_AIE] = alarm_irq_enable_q;
            rdata_d[C2_AF]  = alarm_flag_q;
            rdata_d[C2_MI]  = minute_irq_enable_q;
            rdata_d[C2_HMI] = half_minute_irq_enable_q;
            rdata_d[C2_TF]  = countdown_flag_q;
        end
        else if (reg_addr == ADDR_OFFSET)
            rdata_d = offset_q;
        else if (reg_addr >= ADDR_ALM_FIRST && reg_addr <= ADDR_ALM_LAST)
            rdata_d = alm_q[3'(reg_addr - ADDR_ALM_FIRST)];
        else if (reg_addr == ADDR_TMR_VAL)
            rdata_d = 8'(cnt_q);
        else if (reg_addr == ADDR_TMR_MODE)
        begin
            rdata_d[TM_TD_HI:TM_TD_LO] = countdown_source_select_q;
            rdata_d[TM_TE]             = countdown_run_enable_q;
            rdata_d[TM_TIE]            = countdown_irq_enable_q;
            rdata_d[TM_PULSE]          = countdown_irq_pulse_select_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= ZERO8;
        else if (ce && reg_rd)
            reg_rdata <= rdata_d;
    end

    a_alarm_pin_level: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && alarm_irq_enable_q && alarm_flag_q) |=> !int_n)
        else $error("alarm flag not on pin");

    a_alarm_flag_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && alarm_flag_q && !soft_rst && !(wr_ctrl2 && !reg_wdata[C2_AF]))
        |=> alarm_flag_q)
        else $error("alarm flag dropped by itself");

    a_alarm_set_cause: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(alarm_flag_q) |-> $past(time_adv && match && any_enabled && !match_prev_q))
        else $error("alarm flag set without fresh match");

    a_tflag_on_end: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && end_evt && !soft_rst) |=> countdown_flag_q)
        else $error("timer flag missed countdown end");

    a_tflag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && countdown_flag_q && !soft_rst && !(wr_ctrl2 && !reg_wdata[C2_TF]))
        |=> countdown_flag_q)
        else $error("timer flag cleared by itself");

    a_level_mode_pin: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && countdown_irq_enable_q && !countdown_irq_pulse_select_q && countdown_flag_q)
        |=> !int_n)
        else $error("level mode pin not following flag");

    a_pulse_mode_pin: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && end_evt && !soft_rst && countdown_irq_enable_q
         && countdown_irq_pulse_select_q) |=> ##1 !int_n)
        else $error("no pulse after countdown end");

    a_reload_after_end: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && end_evt && !soft_rst && !wr_val) |=> (cnt_q == $past(countdown_load_value_q)))
        else $error("counter not reloaded");

    a_counter_hold_off: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && !countdown_run_enable_q && !wr_val && !soft_rst) |=> $stable(cnt_q))
        else $error("counter moved while disabled");

    a_live_value_read: assert property (@(posedge sys_clk) disable iff (rst)
        (ce && reg_rd && reg_addr == ADDR_TMR_VAL) |=> (reg_rdata == 8'($past(cnt_q))))
        else $error("timer value read not live");

endmodule : rct_timer_top

/* File: bench/rct_host_model.sv */
// rct_host_model: host side of the byte register port.
// assumes one access at a time; strobes change 1 ns after a rising edge.
`timescale 1ns/1ps
module rct_host_model
(
    input  wire logic       sys_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [4:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge sys_clk) #1;
        {reg_wr, reg_wdata} = {1'b0, ~d};
    endtask : wr

    // the live counter cannot be frozen, so reads repeat, at most four times, until two in a row agree
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        logic [7:0] p;
        d = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            p = d;
            @(posedge sys_clk) #1;
            {reg_rd, reg_addr} = {1'b1, a};
            @(posedge sys_clk) #1;
            reg_rd = 1'b0;
            d = reg_rdata;
            if (i > 0 && p === d)
                break;
        end
    endtask : rd
endmodule : rct_host_model

/* File: bench/rct_timer_top_bench.sv */
// rct_timer_top_bench: self-checking bench of countdown and alarm gating.
// assumes osc_tick every fourth clock, so the 4.096 kHz source ticks every 32.
`timescale 1ns/1ps
module rct_timer_top_bench;
    import rct_pkg::*;
    logic       sys_clk = 0, rst = 1, osc_tick = 0, time_adv = 0, minute_event = 0, comp_extra = 0;
    logic       reg_wr, reg_rd, int_n;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v, rv;
    logic [6:0] cur_sec = 0, cur_rest = 0;
    logic [1:0] osc_q = 0;
    int         err_total = 0, comparisons = 0, n;

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) #1 {osc_q, osc_tick} = {osc_q + 2'h1, osc_q == 2'h3};

    rct_host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    rct_timer_top i_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .osc_tick(osc_tick),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .time_adv(time_adv), .cur_sec(cur_sec), .cur_min(cur_rest),
        .cur_hour(cur_rest), .cur_date(cur_rest), .cur_wday(cur_rest),
        .minute_event(minute_event), .comp_extra(comp_extra), .comp_drop(1'b0), .int_n(int_n));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic wait_pin(input logic lvl, input int lim);
        n = 0;
        while (int_n !== lvl && n < lim)
        begin
            @(posedge sys_clk) #1;
            n++;
        end
        check("int_n", {7'h00, int_n}, {7'h00, lvl});
    endtask : wait_pin

    task automatic adv(input logic [6:0] s);
        @(posedge sys_clk) #1;
        {cur_sec, time_adv} = {s, 1'b1};
        @(posedge sys_clk) #1;
        time_adv = 1'b0;
    endtask : adv

    initial
    begin
        void'($urandom(32'hE7DD5374));
        cur_rest = 7'($urandom());
        repeat (8) @(posedge sys_clk);
        #1 rst = 0;
        i_host.rd(5'h11, v); check("mode", v, TMR_MODE_RST);
        i_host.rd(5'h01, v); check("ctrl2", v, ZERO8);
        rv = 8'($urandom_range(255, 1));
        i_host.wr(5'h10, rv);
        repeat (100) @(posedge sys_clk);
        i_host.rd(5'h10, v); check("held count", v, rv);
        // pulse mode, value 1 at the fast source: period 32 clocks
        i_host.wr(5'h10, ONE8);
        i_host.wr(5'h11, 8'h07);
        wait_pin(1'b0, 100);
        wait_pin(1'b1, 40);
        check("pulse width", {7'h00, n > 12 && n < 21}, ONE8);
        i_host.rd(5'h01, v); check("flag", v, 8'h08);
        wait_pin(1'b0, 60);
        // same value at the 64 Hz source: pulse is 256 oscillator ticks
        i_host.wr(5'h11, 8'h0F);
        wait_pin(1'b1, 20);
        wait_pin(1'b0, 2100);
        wait_pin(1'b1, 1100);
        check("slow pulse", {7'h00, n > 1020 && n < 1028}, ONE8);
        i_host.wr(5'h11, 8'h06);
        i_host.wr(5'h11, 8'h02);
        repeat (3) @(posedge sys_clk);
        check("level pin", {7'h00, int_n}, ZERO8);
        i_host.wr(5'h01, ZERO8);
        wait_pin(1'b1, 3);
        i_host.rd(5'h01, v); check("cleared", v, ZERO8);
        i_host.wr(5'h10, 8'hC8);
        i_host.wr(5'h11, 8'h04);
        repeat (200) @(posedge sys_clk);
        i_host.rd(5'h10, v); check("live", {7'h00, v < 8'hC8 && v > 8'hC0}, ONE8);
        // 1 Hz source with a non-zero offset: an inserted tick must count
        i_host.wr(5'h02, ONE8);
        i_host.wr(5'h11, 8'h14);
        i_host.rd(5'h10, v);
        @(posedge sys_clk) #1 comp_extra = 1'b1;
        @(posedge sys_clk) #1 comp_extra = 1'b0;
        i_host.rd(5'h10, rv); check("extra tick", rv, v - ONE8);
        i_host.wr(5'h0B, 8'h05);
        i_host.wr(5'h01, 8'h80);
        adv(7'h05);
        wait_pin(1'b0, 3);
        i_host.rd(5'h01, v); check("alarm", v, 8'hC0);
        i_host.wr(5'h01, 8'h80);
        adv(7'h05);
        i_host.rd(5'h01, v); check("no refresh", v, 8'h80);
        i_host.wr(5'h0B, 8'h85);
        adv(7'h06);
        adv(7'h05);
        i_host.rd(5'h01, v); check("all off", v, 8'h80);
        i_host.wr(5'h01, 8'h20);
        @(posedge sys_clk) #1 minute_event = 1'b1;
        @(posedge sys_clk) #1 minute_event = 1'b0;
        i_host.rd(5'h01, v); check("minute", v, 8'h28);
        check("gated pin", {7'h00, int_n}, ONE8);
        i_host.wr(5'h00, SOFT_RST_CMD);
        i_host.rd(5'h11, v); check("soft mode", v, TMR_MODE_RST);
        i_host.rd(5'h01, v); check("soft ctrl2", v, ZERO8);
        print_verdict();
    end

    initial
    begin
        #50us;
        err_total++;
        print_verdict();
    end
endmodule : rct_timer_top_bench
